/* File: design/serial_port_pkg.sv */
// Constants shared by the second serial terminal port
package serial_port_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_FIXED = 110;
  localparam int BAUD_MIN = 110;
  localparam int BAUD_MAX = 100_000;
  localparam int BAUD_SPLIT = 10_000;
  localparam int OVS_LOW = 128;
  localparam int OVS_HIGH = 16;
  localparam logic [5:0] DEV_RX = 6'h20;
  localparam logic [5:0] DEV_TX = 6'h21;
  localparam int IOP_SKIP = 0;
  localparam int IOP_CLEAR = 1;
  localparam int IOP_XFER = 2;
  localparam int CHAR_BITS = 8;
  localparam int FRAME_BITS = 10;
  localparam logic [11:0] AC_RST = 12'h000;
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic LINE_IDLE = 1'b1;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_e;
endpackage

/* File: design/serial_terminal_port.sv */
// Second serial terminal port: I/O decode, receiver, bit timing
`timescale 1ns/10ps
`default_nettype none
module serial_terminal_port
  import serial_port_pkg::*;
#(
  parameter int BAUD = BAUD_FIXED,
  parameter int CLK_RATE = CLK_HZ
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Host I/O instruction
  input wire logic ioStrobe,
  input wire logic [5:0] devCode,
  input wire logic [2:0] iopBits,
  input wire logic [11:0] acIn,
  output logic acWrite,
  output logic [11:0] acOut,
  output logic skipReq,
  // Flags
  output logic receiveReadyFlag,
  output logic transmitReadyFlag,
  // Serial line
  input wire logic lineFitted,
  input wire logic rxLine,
  output logic txLine
);
  localparam int OVS = (BAUD < BAUD_SPLIT) ? OVS_LOW : OVS_HIGH;
  localparam int DIV_RAW = CLK_RATE / (BAUD * OVS);
  localparam int DIV = (DIV_RAW < 1) ? 1 : DIV_RAW;
  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);
  localparam logic [7:0] OVS_LAST = 8'(OVS - 1);
  localparam logic [7:0] HALF_LAST = 8'(OVS / 2 - 1);

  tx_link_if tx ();

  // Reference tick and bit tick
  logic [15:0] divCnt_r;
  logic [7:0] ovsCnt_r;
  logic refTick_r;
  logic bitTick_r;
  wire divWrap = (divCnt_r == DIV_LAST);
  wire ovsWrap = (ovsCnt_r == OVS_LAST);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divCnt_r <= 16'h0000;
      ovsCnt_r <= 8'h00;
      refTick_r <= 1'b0;
      bitTick_r <= 1'b0;
    end else if (ce) begin
      divCnt_r <= divWrap ? 16'h0000 : divCnt_r + 16'h0001;
      refTick_r <= divWrap;
      bitTick_r <= divWrap && ovsWrap;
      if (divWrap) begin
        ovsCnt_r <= ovsWrap ? 8'h00 : ovsCnt_r + 8'h01;
      end
    end
  end

  // Receive line synchroniser
  wire rxPin = lineFitted & rxLine;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic rxLvl_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= LINE_IDLE;
      sync2_r <= LINE_IDLE;
      sync3_r <= LINE_IDLE;
      rxLvl_r <= LINE_IDLE;
    end else if (ce) begin
      sync1_r <= rxPin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        rxLvl_r <= sync3_r;
      end
    end
  end

  // Receiver
  rx_state_e rxState_r;
  rx_state_e rxState_nxt;
  logic [7:0] rxTicks_r;
  logic [2:0] rxBits_r;
  logic [7:0] rxShift_r;
  logic [7:0] rxChar_r;
  logic rxDone_r;
  wire midStart = (rxTicks_r == HALF_LAST);
  wire midBit = (rxTicks_r == OVS_LAST);
  wire lastData = (rxBits_r == 3'(CHAR_BITS - 1));

  always_comb begin
    rxState_nxt = rxState_r;
    case (rxState_r)
      RX_IDLE: if (!rxLvl_r) rxState_nxt = RX_START;
      RX_START: if (midStart) rxState_nxt = rxLvl_r ? RX_IDLE : RX_DATA;
      RX_DATA: if (midBit && lastData) rxState_nxt = RX_STOP;
      RX_STOP: if (midBit) rxState_nxt = RX_IDLE;
      default: rxState_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxState_r <= RX_IDLE;
      rxTicks_r <= 8'h00;
      rxBits_r <= 3'h0;
      rxShift_r <= CHAR_RST;
      rxChar_r <= CHAR_RST;
      rxDone_r <= 1'b0;
    end else if (ce) begin
      rxDone_r <= 1'b0;
      if (refTick_r) begin
        rxState_r <= rxState_nxt;
        rxTicks_r <= (rxState_nxt != rxState_r || midBit) ? 8'h00
                     : rxTicks_r + 8'h01;
        if (rxState_r == RX_DATA && midBit) begin
          rxShift_r <= {rxLvl_r, rxShift_r[7:1]};
          rxBits_r <= rxBits_r + 3'h1;
        end
        if (rxState_r == RX_STOP && midBit && rxLvl_r) begin
          rxChar_r <= rxShift_r;
          rxDone_r <= 1'b1;
        end
        if (rxState_r == RX_START) begin
          rxBits_r <= 3'h0;
        end
      end
    end
  end

  // Instruction decode
  wire selRx = ioStrobe && (devCode == DEV_RX);
  wire selTx = ioStrobe && (devCode == DEV_TX);
  wire doSkip = iopBits[IOP_SKIP];
  wire doClear = iopBits[IOP_CLEAR];
  wire doXfer = iopBits[IOP_XFER];
  wire rxFlagSet = rxDone_r && lineFitted;
  wire rxFlagClr = selRx && doClear;
  wire txFlagClr = selTx && doClear;
  wire [11:0] acBase = doClear ? AC_RST : acIn;
  wire [11:0] rxAc = acBase | {4'h0, doXfer ? rxChar_r : CHAR_RST};
  wire skipNow = (selRx && doSkip && receiveReadyFlag)
                 || (selTx && doSkip && transmitReadyFlag);

  assign tx.load = ce && selTx && doXfer && !tx.busy;
  assign tx.data = acIn[7:0];
  assign tx.bitTick = bitTick_r;

  tx_shifter txShifter (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .tx(tx.shifter)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acWrite <= 1'b0;
      acOut <= AC_RST;
      skipReq <= 1'b0;
      receiveReadyFlag <= 1'b0;
      transmitReadyFlag <= 1'b0;
      txLine <= LINE_IDLE;
    end else if (ce) begin
      acWrite <= selRx && (doClear || doXfer);
      acOut <= rxAc;
      skipReq <= skipNow;
      txLine <= tx.line;
      if (rxFlagSet) begin
        receiveReadyFlag <= 1'b1;
      end else if (rxFlagClr) begin
        receiveReadyFlag <= 1'b0;
      end
      if (tx.done) begin
        transmitReadyFlag <= 1'b1;
      end else if (txFlagClr) begin
        transmitReadyFlag <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/tx_link_if.sv */
// Carrier between the port controller and its transmit shifter
`timescale 1ns/10ps
`default_nettype none
interface tx_link_if;
  logic load;
  logic [7:0] data;
  logic bitTick;
  logic done;
  logic busy;
  logic line;
  modport ctrl (output load, data, bitTick, input done, busy, line);
  modport shifter (input load, data, bitTick, output done, busy, line);
endinterface
`default_nettype wire

/* File: design/tx_shifter.sv */
// Transmit shifter: frames and sends one character
`timescale 1ns/10ps
`default_nettype none
module tx_shifter
  import serial_port_pkg::*;
(
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Link to controller
  tx_link_if.shifter tx
);
  logic [FRAME_BITS-1:0] shift_r;
  logic [3:0] cnt_r;
  logic busy_r;
  logic line_r;
  logic done_r;
  wire lastBit = (cnt_r == 4'(FRAME_BITS));
  wire take = tx.load && !busy_r;

  assign tx.busy = busy_r;
  assign tx.line = line_r;
  assign tx.done = done_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_r <= '1;
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      line_r <= LINE_IDLE;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (take) begin
        shift_r <= {1'b1, tx.data, 1'b0};
        cnt_r <= 4'h0;
        busy_r <= 1'b1;
      end else if (busy_r && tx.bitTick) begin
        if (lastBit) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          line_r <= shift_r[0];
          shift_r <= {1'b1, shift_r[FRAME_BITS-1:1]};
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/remote_terminal.sv */
// Remote terminal model on the far end of the serial line
`timescale 1ns/10ps
`default_nettype none
module remote_terminal #(
  parameter int BIT_NS = 9600
) (
  // Serial line and report
  input wire logic txLine,
  output logic rxLine,
  output logic [7:0] heard
);
  initial rxLine = 1'b1;
  task automatic send(input logic [7:0] c);
    rxLine = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      rxLine = c[i];
      #BIT_NS;
    end
    rxLine = 1'b1;
    #BIT_NS;
  endtask
  always begin
    @(negedge txLine);
    #(BIT_NS / 2 * 3);
    for (int i = 0; i < 8; i++) begin
      heard[i] = txLine;
      #BIT_NS;
    end
  end
endmodule
`default_nettype wire

/* File: verification/serial_port_checker.sv */
// Port checker for the second serial terminal port
`timescale 1ns/10ps
`default_nettype none
module serial_port_checker
  import serial_port_pkg::*;
(
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Host side
  input wire logic ioStrobe,
  input wire logic [5:0] devCode,
  input wire logic [2:0] iopBits,
  input wire logic [11:0] acIn,
  input wire logic [11:0] acOut,
  input wire logic acWrite,
  input wire logic skipReq,
  // Flags and line
  input wire logic receiveReadyFlag,
  input wire logic transmitReadyFlag,
  input wire logic lineFitted,
  input wire logic rxLine,
  input wire logic txLine
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic rxIns = ce && ioStrobe && devCode == DEV_RX;
  sequence readStatic;
    rxIns && iopBits == 3'b100;
  endsequence
  sequence orResult;
    acWrite && (acOut | $past(acIn)) == acOut
      && acOut[11:8] == $past(acIn[11:8]);
  endsequence
  a_skip_when_ready:
    assert property (rxIns && iopBits[0] && receiveReadyFlag |=> skipReq)
    else $error("skip missing");
  a_read_static_or:
    assert property (readStatic |=> orResult) else $error("read wrong");
  a_flag_holds:
    assert property (receiveReadyFlag && !(rxIns && iopBits[1])
      |=> receiveReadyFlag) else $error("flag lost");
  a_tx_no_write:
    assert property (ce && ioStrobe && devCode == DEV_TX |=> !acWrite)
    else $error("write on tx");
  a_write_has_cause:
    assert property (acWrite |-> $past(ioStrobe) && $past(devCode) == DEV_RX)
    else $error("stray write");
  a_skip_has_cause:
    assert property (skipReq |-> $past(ioStrobe)
      && ($past(receiveReadyFlag) || $past(transmitReadyFlag)))
    else $error("stray skip");
  a_unfitted_quiet:
    assert property (!lineFitted [*8] |-> !$rose(receiveReadyFlag))
    else $error("flag while unfitted");
  a_ready_line_idle:
    assert property ($rose(transmitReadyFlag) |-> txLine)
    else $error("line busy at ready");
endmodule
`default_nettype wire

/* File: verification/serial_terminal_port_test.sv */
// Self-checking bench for the second serial terminal port
`timescale 1ns/10ps
`default_nettype none
module serial_terminal_port_test;
  import serial_port_pkg::*;
  localparam int BIT_NS = 6 * OVS_HIGH * 100;
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, ioStrobe = 1'b0;
  logic lineFitted = 1'b1;
  logic [5:0] devCode = 6'h00;
  logic [2:0] iopBits = 3'h0;
  logic [11:0] acIn = 12'h000, acOut;
  logic acWrite, skipReq, receiveReadyFlag, transmitReadyFlag;
  logic rxLine, txLine;
  logic [7:0] heard;
  int err_count = 0, checks = 0, cycles = 0, n;
  serial_terminal_port #(.BAUD(100_000)) uut (
    .core_clk, .rst, .ce, .ioStrobe, .devCode, .iopBits, .acIn,
    .acWrite, .acOut, .skipReq, .receiveReadyFlag, .transmitReadyFlag,
    .lineFitted, .rxLine, .txLine);
  remote_terminal #(.BIT_NS(BIT_NS)) far (.txLine, .rxLine, .heard);
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic io(input logic [5:0] d, input logic [2:0] op,
                    input logic [11:0] a);
    @(negedge core_clk);
    ioStrobe = 1'b1;
    devCode = d;
    iopBits = op;
    acIn = a;
    @(negedge core_clk);
    // Return while the one-cycle answer still stands
    ioStrobe = 1'b0;
  endtask
  task automatic waitFlag(input bit tx);
    for (n = 0; n < 3000; n++) begin
      @(negedge core_clk);
      if ((tx ? transmitReadyFlag : receiveReadyFlag) === 1'b1) break;
    end
  endtask
  task automatic t_receive();
    far.send(8'h5a);
    waitFlag(1'b0);
    chk({11'h0, receiveReadyFlag}, 12'h001);
    io(DEV_RX, 3'b001, 12'h000);
    chk({11'h0, skipReq}, 12'h001);
    io(6'h22, 3'b111, 12'h123);
    chk({10'h0, acWrite, skipReq}, 12'h000);
    io(DEV_RX, 3'b100, 12'h801);
    chk(acOut, 12'h85b);
    chk({11'h0, receiveReadyFlag}, 12'h001);
    io(DEV_RX, 3'b010, 12'h7ff);
    chk(acOut, 12'h000);
    chk({11'h0, receiveReadyFlag}, 12'h000);
    io(DEV_RX, 3'b001, 12'h000);
    chk({11'h0, skipReq}, 12'h000);
  endtask
  task automatic t_duplex();
    fork
      far.send(8'h3c);
      io(DEV_TX, 3'b100, 12'hfc3);
    join
    waitFlag(1'b1);
    chk({4'h0, heard}, 12'h0c3);
    io(DEV_TX, 3'b001, 12'h000);
    chk({11'h0, skipReq}, 12'h001);
    io(DEV_RX, 3'b110, 12'hfff);
    chk(acOut, 12'h03c);
    io(DEV_TX, 3'b010, 12'h000);
    chk({10'h0, receiveReadyFlag, transmitReadyFlag}, 12'h000);
    io(DEV_TX, 3'b001, 12'h000);
    chk({11'h0, skipReq}, 12'h000);
  endtask
  task automatic t_freeze();
    @(negedge core_clk);
    ce = 1'b0;
    io(DEV_RX, 3'b110, 12'h5a5);
    chk({acWrite, acOut[10:0]}, 12'h000);
    ce = 1'b1;
  endtask
  task automatic t_unfitted();
    lineFitted = 1'b0;
    far.send(8'hff);
    repeat (200) @(negedge core_clk);
    chk({11'h0, receiveReadyFlag}, 12'h000);
    lineFitted = 1'b1;
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk({9'h0, txLine, receiveReadyFlag, transmitReadyFlag}, 12'h004);
    t_receive();
    t_duplex();
    t_freeze();
    t_unfitted();
    finish_test();
  end
endmodule
bind serial_terminal_port serial_port_checker portChk (
  .core_clk, .rst, .ce, .ioStrobe, .devCode, .iopBits, .acIn, .acOut,
  .acWrite, .skipReq, .receiveReadyFlag, .transmitReadyFlag,
  .lineFitted, .rxLine, .txLine);
`default_nettype wire
